// ---- pkg/wdc_defines.vh ----
// Constants for the write-data byte-mask capture stage.
// Assumes inclusion by bare name from design files.
`ifndef WDC_DEFINES_VH
`define WDC_DEFINES_VH
`define WDC_ORG_X8        2'd0
`define WDC_ORG_X9        2'd1
`define WDC_ORG_X18       2'd2
`define WDC_ORG_X36       2'd3
`define WDC_DATA_W        36
`define WDC_MASK_W        4
`define WDC_LANE_W        9
`define WDC_NIB_W         4
`define WDC_BURST_LEN     4
`define WDC_MASK_IDLE     4'hf
`endif

// ---- hw/wdc_lane_merge.v ----
// Merges one captured burst word into a stored word under active-low masks.
// Assumes raw pin masks from the caller; org selects nibble or byte lanes here.
`timescale 1ns/1ps
`include "wdc_defines.vh"
module wdc_lane_merge (
  input  wire [1:0]               org,
  input  wire [`WDC_DATA_W-1:0]   old_word,
  input  wire [`WDC_DATA_W-1:0]   new_word,
  input  wire [`WDC_MASK_W-1:0]   byte_lane_write_mask_n,
  input  wire [1:0]               nibble_lane_write_mask_n,
  output wire [`WDC_DATA_W-1:0]   merged
);
  genvar i;
  generate
    for (i = 0; i < `WDC_DATA_W; i = i + 1) begin : g_bit
      wire keep_x9;
      wire keep_x8;
      // Bit i belongs to lane i/9; x8 uses nibble i/4
      assign keep_x9 = byte_lane_write_mask_n[i / `WDC_LANE_W];
      // Only the low byte has nibble masks; the index stays in range
      if (i < 8) begin : g_nib
        assign keep_x8 = nibble_lane_write_mask_n[i / `WDC_NIB_W];
      end else begin : g_no_nib
        assign keep_x8 = 1'b1;
      end
      assign merged[i] = ((org == `WDC_ORG_X8) ? keep_x8 : keep_x9) ?
                         old_word[i] : new_word[i];
    end
  endgenerate
endmodule // wdc_lane_merge

// ---- hw/wdc_write_capture.v ----
// Write-data input stage: captures burst words and masks on K and K-bar.
// Assumes k_rise / kb_rise are one-cycle strobes marking each clock edge,
// synchronous to clk, with data and masks valid alongside.
//
// Behaviour
// - Write data is sampled on K and K-bar rising edges only while a write is running.
// - Data width follows organisation: 8, 9, 18 or 36 bits.
// - Byte masks are active low and sampled on both K and K-bar edges during writes.
// - Each mask sample applies to the data word taken on the same edge.
// - Masks of an edge select the bytes stored for the burst word of that edge.
// - A high mask discards its byte and leaves the stored byte unchanged.
// - In x9 mask 0 covers bits 8..0; in x18 mask 1 also covers bits 17..9.
// - A write starts on a K edge with select low; words follow from the next K edge.
// - x8 parts use two active-low nibble masks sampled with the data.
`timescale 1ns/1ps
`include "wdc_defines.vh"
module wdc_write_capture (
  input  wire                       clk,
  input  wire                       srst,
  input  wire [1:0]                 org,
  input  wire                       k_rise,
  input  wire                       kb_rise,
  input  wire                       write_sel_n,
  input  wire                       read_sel_n,
  input  wire [`WDC_DATA_W-1:0]     wr_data,
  input  wire [`WDC_MASK_W-1:0]     byte_lane_write_mask_n,
  input  wire [1:0]                 nibble_lane_write_mask_n,
  output wire                       busy,
  output reg  [4*`WDC_DATA_W-1:0]   burst_word_reg,
  output reg                        burst_done_reg
);
  localparam ST_IDLE  = 2'd0;
  localparam ST_ARMED = 2'd1;
  localparam ST_DATA  = 2'd2;

  reg  [1:0]              state_reg;
  reg  [1:0]              state_next;
  reg  [1:0]              beat_reg;
  reg  [1:0]              beat_next;
  reg                     done_next;
  reg  [`WDC_DATA_W-1:0]  width_mask;
  wire [4*`WDC_DATA_W-1:0] word_next;
  wire [1:0]              cap_beat;
  wire [`WDC_BURST_LEN-1:0] beat_we;
  wire                    first_word;
  wire                    capture;
  wire [`WDC_DATA_W-1:0]  data_in;
  wire [`WDC_DATA_W-1:0]  old_beat;
  wire [`WDC_DATA_W-1:0]  merged_beat;
  wire                    edge_ok;
  wire                    start;

  // Unused upper pins are forced to zero per organisation
  always @* begin
    if (org == `WDC_ORG_X8) begin
      width_mask = 36'h0000000ff;
    end else if (org == `WDC_ORG_X9) begin
      width_mask = 36'h0000001ff;
    end else if (org == `WDC_ORG_X18) begin
      width_mask = 36'h00003ffff;
    end else begin
      width_mask = 36'hfffffffff;
    end
  end

  assign data_in = wr_data & width_mask;

  // Read wins over a simultaneous write request
  assign start = k_rise && !write_sel_n && read_sel_n && state_reg == ST_IDLE;

  // Beats 0 and 2 on K, beats 1 and 3 on K-bar
  assign edge_ok = (state_reg == ST_DATA) &&
                   (beat_reg[0] ? kb_rise : k_rise);
  assign busy = (state_reg != ST_IDLE);

  // Beat 0 is taken from the armed state, later beats from the data state
  assign first_word = (state_reg == ST_ARMED) && k_rise;
  assign capture    = first_word || edge_ok;
  assign cap_beat   = first_word ? 2'd0 : beat_reg;

  assign old_beat = burst_word_reg[cap_beat*`WDC_DATA_W +: `WDC_DATA_W];

  wdc_lane_merge u_merge (
    .org                      (org),
    .old_word                 (old_beat),
    .new_word                 (data_in),
    .byte_lane_write_mask_n   (byte_lane_write_mask_n),
    .nibble_lane_write_mask_n (nibble_lane_write_mask_n),
    .merged                   (merged_beat)
  );

  // One strobe per beat slot; only the slot being captured takes the merge
  genvar b;
  generate
    for (b = 0; b < `WDC_BURST_LEN; b = b + 1) begin : g_beat
      assign beat_we[b] = capture && ({30'h0, cap_beat} == b);
      assign word_next[b*`WDC_DATA_W +: `WDC_DATA_W] =
               beat_we[b] ? merged_beat :
                            burst_word_reg[b*`WDC_DATA_W +: `WDC_DATA_W];
    end
  endgenerate

  // State sequencing
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_ARMED;
        end
      end
      ST_ARMED: begin
        // First word rides the K edge after the address edge
        if (first_word) begin
          state_next = ST_DATA;
        end
      end
      ST_DATA: begin
        if (edge_ok && (beat_reg == 2'd3)) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // Beat counter; wraps to zero after the last beat
  always @* begin
    beat_next = beat_reg;
    case (state_reg)
      ST_IDLE: begin
        beat_next = 2'd0;
      end
      ST_ARMED: begin
        if (first_word) begin
          beat_next = 2'd1;
        end
      end
      ST_DATA: begin
        if (edge_ok) begin
          beat_next = beat_reg + 2'd1;
        end
      end
      default: begin
        beat_next = 2'd0;
      end
    endcase
  end

  // Completion pulse after the fourth word
  always @* begin
    done_next = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        done_next = 1'b0;
      end
      ST_ARMED: begin
        done_next = 1'b0;
      end
      ST_DATA: begin
        if (edge_ok && (beat_reg == 2'd3)) begin
          done_next = 1'b1;
        end
      end
      default: begin
        done_next = 1'b0;
      end
    endcase
  end

  always @(posedge clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      beat_reg <= 2'd0;
    end else begin
      beat_reg <= beat_next;
    end
  end

  // Stored word; masked lanes keep their previous contents
  always @(posedge clk) begin
    if (srst) begin
      burst_word_reg <= {4*`WDC_DATA_W{1'b0}};
    end else begin
      burst_word_reg <= word_next;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      burst_done_reg <= 1'b0;
    end else begin
      burst_done_reg <= done_next;
    end
  end

endmodule // wdc_write_capture

// ---- test/wdc_write_capture_properties.sv ----
// Write capture port properties.
// Assumes bind to wdc_write_capture.
`timescale 1ns/1ps
module wdc_write_capture_properties (
  input clk, srst, k_rise, kb_rise, write_sel_n, read_sel_n, busy, burst_done_reg,
  input [1:0] org, input [35:0] wr_data, input [3:0] byte_lane_write_mask_n,
  input [143:0] burst_word_reg);
  wire st = k_rise & ~write_sel_n & read_sel_n & ~busy;
  wire x36 = org == 2'h3;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  done_due_a: assert property (st ##1 k_rise ##1 kb_rise ##1 k_rise ##1 kb_rise
    |=> burst_done_reg) else $error("no done");
  done_once_a: assert property (burst_done_reg |=> !burst_done_reg) else $error("long");
  busy_hold_a: assert property (st |=> busy [*3]) else $error("busy low");
  busy_end_a: assert property (burst_done_reg |-> !busy) else $error("busy high");
  read_wins_a: assert property (k_rise && !read_sel_n && !busy |=> !busy) else $error("rd");
  no_start_a: assert property (!busy && write_sel_n |=> !busy) else $error("idle");
  beat_write_a: assert property (st ##1 (byte_lane_write_mask_n == 4'h0 && x36) |=> ##3
    burst_word_reg[35:0] == $past(wr_data, 4)) else $error("beat0");
  beat_keep_a: assert property (st ##4 (byte_lane_write_mask_n == 4'hf && x36) |=>
    burst_word_reg[143:108] == $past(burst_word_reg[143:108], 5)) else $error("beat3");
endmodule // wdc_write_capture_properties
bind wdc_write_capture wdc_write_capture_properties u_props (.*);

// ---- test/wdc_ctrl_model.sv ----
// Controller model: start, then K, K-bar, K, K-bar beats.
// Assumes words and masks are loaded before req.
`timescale 1ns/1ps
module wdc_ctrl_model (
  input clk, req, input [35:0] dw [4], input [3:0] mw [4],
  output k_rise, kb_rise, write_sel_n, output [35:0] wr_data,
  output [3:0] byte_lane_write_mask_n);
  reg  [2:0] ph_reg = 3'h0;
  wire [1:0] bi = ph_reg[1:0] + 2'h2;
  wire       on = ph_reg > 3'h1;
  always @(negedge clk)
    ph_reg <= ph_reg == 3'h5 ? 3'h0 : ph_reg != 3'h0 ? ph_reg + 3'h1 : {2'h0, req};
  assign write_sel_n = ph_reg != 3'h1;
  assign k_rise = ph_reg == 3'h1 || ph_reg == 3'h2 || ph_reg == 3'h4;
  assign kb_rise = ph_reg == 3'h3 || ph_reg == 3'h5;
  assign wr_data = on ? dw[bi] : ~dw[bi];
  assign byte_lane_write_mask_n = on ? mw[bi] : ~mw[bi];
endmodule // wdc_ctrl_model

// ---- test/wdc_write_capture_tb_top.sv ----
// Bench: org and mask sweep, then a start lost to a read.
// Assumes wdc_ctrl_model drives strobes and data.
`timescale 1ns/1ps
module wdc_write_capture_tb_top;
  reg clk = 1'h0, srst = 1'h1, req = 1'h0, read_sel_n = 1'h1;
  reg [1:0] org = 2'h3;
  reg [35:0] dw [4] = '{default: 36'h0};
  reg [3:0] mw [4] = '{default: 4'hf};
  reg [143:0] ew = 144'h0;
  integer fails = 0, checks = 0, cyc = 0;
  wire k_rise, kb_rise, write_sel_n, busy, burst_done_reg;
  wire [35:0] wr_data;
  wire [3:0] byte_lane_write_mask_n;
  wire [1:0] nibble_lane_write_mask_n = byte_lane_write_mask_n[1:0];
  wire [143:0] burst_word_reg;
  always #5 clk = ~clk;
  wdc_ctrl_model u_ctrl (.*);
  wdc_write_capture DUT (.*);
  task chk(input string n, input [35:0] s, input [35:0] e);
    checks = checks + 1;
    if (s !== e) begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task burst;
    integer t;
    req <= 1'h1;
    @(negedge clk) req <= 1'h0;
    for (t = 0; t < 9 && burst_done_reg !== 1'h1; t = t + 1) @(negedge clk);
  endtask
  task t_orgs;
    integer o, b, i;
    reg [35:0] wm;
    for (o = 7; o >= 0; o = o - 1) begin
      org = o[2:1];
      wm = ~(36'hf_ffff_ffff << (o < 2 ? 8 : o < 4 ? 9 : o < 6 ? 18 : 36));
      for (b = 0; b < 4; b = b + 1) begin
        dw[b] = 36'h9a5c3e71b * (b + 4 * o + 1);
        mw[b] = {2{b[0], b[1]}} ^ {4{o[0]}};
        for (i = 0; i < 36; i = i + 1)
          if (mw[b][o < 2 ? i / 4 : i / 9] === 1'h0) ew[36 * b + i] = dw[b][i];
      end
      burst;
      chk("done", burst_done_reg, 36'h1);
      for (b = 0; b < 4; b = b + 1)
        chk("beat", burst_word_reg[36 * b +: 36] & wm, ew[36 * b +: 36] & wm);
    end
  endtask
  task t_read;
    read_sel_n = 1'h0;
    dw[0] = ~dw[0];
    burst;
    chk("done", burst_done_reg, 36'h0);
    chk("busy", busy, 36'h0);
    chk("beat", burst_word_reg[7:0], ew[7:0]);
    read_sel_n = 1'h1;
  endtask
  task close_out;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    srst = 1'h0;
    t_orgs;
    t_read;
    close_out;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 400) begin
      fails = fails + 1;
      close_out;
    end
  end
endmodule // wdc_write_capture_tb_top
